// ---- include/ofs_pkg.sv ----
/*
  Constants, register map and types of the output function selector.
  Assumes a 25 MHz system clock and an AXI4-Lite master on the other side.
*/
// How it works
// - Four terminals each pick from one code list
// - Fast terminal: pulse output or level output
// - Code zero leaves terminal OFF
// - Codes 1-4: running, forward, reverse, jogging
// - Code 5: ON during drive fault
// - Codes 6-8: level flags and frequency reached
// - Code 9: output and reference frequency zero
// - Codes 10-11: upper or lower limit reached
// - Code 12: powered, unprotected and ready
// - Code 13: ON during pre-excitation
// - Codes 14-15: overload or underload pre-alarm
// - Codes 16-17: sequencer stage or cycle done
// - Codes 23-25 mirror virtual link bits
// - Code 26: DC bus above undervoltage
// - Code 27: index pulse held 10 ms
// - Code 28: pulse superposition active
// - Code 29: safe torque off fault
// - Codes 30-32: positioning, zeroing, division done
// - Code 33: speed limited in torque control
package ofs_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [4:0] OFS_ADDR_CODE = 5'h00;
  localparam logic [4:0] OFS_ADDR_CTRL = 5'h04;
  localparam logic [4:0] OFS_ADDR_VIRT = 5'h08;
  localparam logic [4:0] OFS_ADDR_STAT = 5'h0c;

  localparam logic [31:0] OFS_RST_CODE = 32'h0000_0000;
  localparam logic [31:0] OFS_RST_VIRT = 32'h0000_0000;
  localparam int          OFS_VIRT_LINK_POS = 8;
  localparam int          OFS_STAT_HOLD_POS = 8;

  localparam logic [1:0] OFS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] OFS_RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int OFS_CLK_HZ      = 25_000_000;
  localparam int OFS_INDEX_MS    = 10;
  localparam int OFS_INDEX_HOLD  = (OFS_CLK_HZ / 1000) * OFS_INDEX_MS;

  // ---------------------------------------------------------------
  // Function codes
  // ---------------------------------------------------------------
  localparam logic [5:0] FC_NONE      = 6'h00;
  localparam logic [5:0] FC_RUN       = 6'h01;
  localparam logic [5:0] FC_RUN_FWD   = 6'h02;
  localparam logic [5:0] FC_RUN_REV   = 6'h03;
  localparam logic [5:0] FC_JOG       = 6'h04;
  localparam logic [5:0] FC_FAULT     = 6'h05;
  localparam logic [5:0] FC_LEVEL_1   = 6'h06;
  localparam logic [5:0] FC_LEVEL_2   = 6'h07;
  localparam logic [5:0] FC_REACHED   = 6'h08;
  localparam logic [5:0] FC_ZERO_SPD  = 6'h09;
  localparam logic [5:0] FC_UPPER     = 6'h0a;
  localparam logic [5:0] FC_LOWER     = 6'h0b;
  localparam logic [5:0] FC_READY     = 6'h0c;
  localparam logic [5:0] FC_PREEXC    = 6'h0d;
  localparam logic [5:0] FC_OVERLOAD  = 6'h0e;
  localparam logic [5:0] FC_UNDERLOAD = 6'h0f;
  localparam logic [5:0] FC_SEQ_STAGE = 6'h10;
  localparam logic [5:0] FC_SEQ_CYCLE = 6'h11;
  localparam logic [5:0] FC_VIRT_1    = 6'h17;
  localparam logic [5:0] FC_VIRT_2    = 6'h18;
  localparam logic [5:0] FC_VIRT_3    = 6'h19;
  localparam logic [5:0] FC_BUS_OK    = 6'h1a;
  localparam logic [5:0] FC_INDEX     = 6'h1b;
  localparam logic [5:0] FC_SUPERPOS  = 6'h1c;
  localparam logic [5:0] FC_SAFE_OFF  = 6'h1d;
  localparam logic [5:0] FC_POS_DONE  = 6'h1e;
  localparam logic [5:0] FC_ZERO_DONE = 6'h1f;
  localparam logic [5:0] FC_DIV_DONE  = 6'h20;
  localparam logic [5:0] FC_SPD_LIM   = 6'h21;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic {
    OFS_FAST_LEVEL = 1'b0,
    OFS_FAST_PULSE = 1'b1
  } ofs_fast_mode_e;

  typedef struct packed {
    logic freqOut;
    logic running;
    logic runFwd;
    logic runRev;
    logic jogging;
    logic fault;
    logic levelOne;
    logic levelTwo;
    logic reached;
    logic outFreqZero;
    logic refFreqZero;
    logic upperLimit;
    logic lowerLimit;
    logic mainPowerOk;
    logic ctrlPowerOk;
    logic protectActive;
    logic readyToRun;
    logic preExcite;
    logic overloadAlarm;
    logic underloadAlarm;
    logic seqStageDone;
    logic seqCycleDone;
    logic busAboveUv;
    logic indexHeld;
    logic superpose;
    logic safeOffFault;
    logic positionDone;
    logic spindleZeroDone;
    logic spindleDivDone;
    logic torqueSpeedLimit;
  } ofs_status_s;

endpackage : ofs_pkg

// ---- include/ofs_stretch_if.sv ----
/*
  Carrier between the selector and its index pulse stretcher.
  Assumes both ends share the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface ofs_stretch_if;
  logic trigger;
  logic active;
  modport ctl     (output trigger, input active);
  modport stretch (input trigger, output active);
endinterface : ofs_stretch_if
`default_nettype wire

// ---- hw/ofs_pulse_stretch.sv ----
/*
  Retriggerable one-shot that holds the index pulse for a fixed time.
  Assumes a one-cycle trigger pulse synchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module ofs_pulse_stretch #(
  parameter int HOLD_CYCLES = ofs_pkg::OFS_INDEX_HOLD
) (
  input  wire logic    clk_sys,
  input  wire logic    rstn,
  ofs_stretch_if.stretch link
);

  typedef struct packed {
    logic        active;
    logic [31:0] count;
  } ofs_stretch_s;

  ofs_stretch_s st;
  ofs_stretch_s next_st;

  // ---------------------------------------------------------------
  // Hold counter
  // ---------------------------------------------------------------
  // A new index pulse restarts the full hold time
  always_comb begin
    next_st = st;
    if (link.trigger) begin
      next_st.active = 1'b1;
      next_st.count  = 32'(HOLD_CYCLES - 1);
    end else if (st.active) begin
      if (st.count == 32'h0000_0000) begin
        next_st.active = 1'b0;
      end else begin
        next_st.count = st.count - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign link.active = st.active;

endmodule : ofs_pulse_stretch
`default_nettype wire

// ---- hw/ofs_top.sv ----
/*
  Output function selector: four terminals, each driven by a chosen
  drive condition, configured over AXI4-Lite.
  Assumes all status inputs are synchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module ofs_top #(
  parameter int ADDR_W      = 5,
  parameter int HOLD_CYCLES = ofs_pkg::OFS_INDEX_HOLD
) (
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Drive conditions
  input  wire logic              freqOut,
  input  wire logic              running,
  input  wire logic              runFwd,
  input  wire logic              runRev,
  input  wire logic              jogging,
  input  wire logic              fault,
  input  wire logic              freq_level_flag_one,
  input  wire logic              freq_level_flag_two,
  input  wire logic              freqReached,
  input  wire logic              outFreqZero,
  input  wire logic              refFreqZero,
  input  wire logic              upperLimit,
  input  wire logic              lowerLimit,
  input  wire logic              mainPowerOk,
  input  wire logic              ctrlPowerOk,
  input  wire logic              protectActive,
  input  wire logic              readyToRun,
  input  wire logic              preExcite,
  input  wire logic              overloadAlarm,
  input  wire logic              underloadAlarm,
  input  wire logic              seqStageDone,
  input  wire logic              seqCycleDone,
  input  wire logic              busAboveUv,
  input  wire logic              encIndex,
  input  wire logic              superpose,
  input  wire logic              safe_torque_off,
  input  wire logic              positionDone,
  input  wire logic              spindleZeroDone,
  input  wire logic              spindleDivDone,
  input  wire logic              torqueSpeedLimit,
  input  wire logic              fastPulseIn,
  // Terminals
  output logic                   relayOne,
  output logic                   relayTwo,
  output logic                   openCollector,
  output logic                   fast_pulse_terminal
);

  typedef struct packed {
    logic              awready;
    logic              awHeld;
    logic [ADDR_W-1:0] awAddr;
    logic              wready;
    logic              wHeld;
    logic [31:0]       wData;
    logic [3:0]        wStrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [31:0]       codes;
    ofs_pkg::ofs_fast_mode_e fastMode;
    logic [31:0]       virt;
    logic              indexPrev;
    logic [3:0]        term;
  } ofs_top_s;

  ofs_top_s             st;
  ofs_top_s             next_st;
  ofs_pkg::ofs_status_s stat;
  ofs_stretch_if        hold ();

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] mergeBytes(
    input logic [31:0] oldVal,
    input logic [31:0] newVal,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = oldVal;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = newVal[b*8 +: 8];
      end
    end
    return res;
  endfunction : mergeBytes

  // Returns 1 when the address hits one of the four words
  function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
    logic [4:0] a;
    a = 5'(addr);
    return (addr[1:0] == 2'h0) && (a <= ofs_pkg::OFS_ADDR_STAT)
           && ((addr >> 5) == '0);
  endfunction : isMapped

  // Every undefined code falls to the default and gives OFF
  function automatic logic termOn(
    input logic [5:0]           code,
    input ofs_pkg::ofs_status_s s,
    input logic [2:0]           virtBits
  );
    logic on;
    on = 1'b0;
    case (code)
      ofs_pkg::FC_NONE:      on = 1'b0;
      ofs_pkg::FC_RUN:       on = s.freqOut & s.running;
      ofs_pkg::FC_RUN_FWD:   on = s.freqOut & s.runFwd;
      ofs_pkg::FC_RUN_REV:   on = s.freqOut & s.runRev;
      ofs_pkg::FC_JOG:       on = s.freqOut & s.jogging;
      ofs_pkg::FC_FAULT:     on = s.fault;
      ofs_pkg::FC_LEVEL_1:   on = s.levelOne;
      ofs_pkg::FC_LEVEL_2:   on = s.levelTwo;
      ofs_pkg::FC_REACHED:   on = s.reached;
      ofs_pkg::FC_ZERO_SPD:  on = s.outFreqZero & s.refFreqZero;
      ofs_pkg::FC_UPPER:     on = s.upperLimit;
      ofs_pkg::FC_LOWER:     on = s.lowerLimit;
      ofs_pkg::FC_READY:     on = s.mainPowerOk & s.ctrlPowerOk
                                  & ~s.protectActive & s.readyToRun;
      ofs_pkg::FC_PREEXC:    on = s.preExcite;
      ofs_pkg::FC_OVERLOAD:  on = s.overloadAlarm;
      ofs_pkg::FC_UNDERLOAD: on = s.underloadAlarm;
      ofs_pkg::FC_SEQ_STAGE: on = s.seqStageDone;
      ofs_pkg::FC_SEQ_CYCLE: on = s.seqCycleDone;
      ofs_pkg::FC_VIRT_1:    on = virtBits[0];
      ofs_pkg::FC_VIRT_2:    on = virtBits[1];
      ofs_pkg::FC_VIRT_3:    on = virtBits[2];
      ofs_pkg::FC_BUS_OK:    on = s.busAboveUv;
      ofs_pkg::FC_INDEX:     on = s.indexHeld;
      ofs_pkg::FC_SUPERPOS:  on = s.superpose;
      ofs_pkg::FC_SAFE_OFF:  on = s.safeOffFault;
      ofs_pkg::FC_POS_DONE:  on = s.positionDone;
      ofs_pkg::FC_ZERO_DONE: on = s.spindleZeroDone;
      ofs_pkg::FC_DIV_DONE:  on = s.spindleDivDone;
      ofs_pkg::FC_SPD_LIM:   on = s.torqueSpeedLimit;
      default:               on = 1'b0;
    endcase
    return on;
  endfunction : termOn

  // ---------------------------------------------------------------
  // Status gathering
  // ---------------------------------------------------------------
  always_comb begin
    stat.freqOut          = freqOut;
    stat.running          = running;
    stat.runFwd           = runFwd;
    stat.runRev           = runRev;
    stat.jogging          = jogging;
    stat.fault            = fault;
    stat.levelOne         = freq_level_flag_one;
    stat.levelTwo         = freq_level_flag_two;
    stat.reached          = freqReached;
    stat.outFreqZero      = outFreqZero;
    stat.refFreqZero      = refFreqZero;
    stat.upperLimit       = upperLimit;
    stat.lowerLimit       = lowerLimit;
    stat.mainPowerOk      = mainPowerOk;
    stat.ctrlPowerOk      = ctrlPowerOk;
    stat.protectActive    = protectActive;
    stat.readyToRun       = readyToRun;
    stat.preExcite        = preExcite;
    stat.overloadAlarm    = overloadAlarm;
    stat.underloadAlarm   = underloadAlarm;
    stat.seqStageDone     = seqStageDone;
    stat.seqCycleDone     = seqCycleDone;
    stat.busAboveUv       = busAboveUv;
    stat.indexHeld        = hold.active;
    stat.superpose        = superpose;
    stat.safeOffFault     = safe_torque_off;
    stat.positionDone     = positionDone;
    stat.spindleZeroDone  = spindleZeroDone;
    stat.spindleDivDone   = spindleDivDone;
    stat.torqueSpeedLimit = torqueSpeedLimit;
  end

  // ---------------------------------------------------------------
  // Index pulse stretcher
  // ---------------------------------------------------------------
  // Rising edge only, so a long index level does not extend the hold
  assign hold.trigger = encIndex & ~st.indexPrev;

  ofs_pulse_stretch #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_stretch (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .link    (hold)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [4:0] wa;
    logic [4:0] ra;
    logic [2:0] vb;
    logic       on;
    wa = 5'h00;
    ra = 5'h00;
    vb = 3'h0;
    on = 1'b0;
    next_st = st;
    next_st.indexPrev = encIndex;

    // Write channel: address and data may come in either order
    if (st.awready && awvalid) begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = awaddr;
    end
    if (st.wready && wvalid) begin
      next_st.wHeld = 1'b1;
      next_st.wData = wdata;
      next_st.wStrb = wstrb;
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    if (next_st.awHeld && next_st.wHeld && !st.bvalid) begin
      wa = 5'(next_st.awAddr);
      next_st.awHeld = 1'b0;
      next_st.wHeld  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = ofs_pkg::OFS_RESP_OKAY;
      if (!isMapped(next_st.awAddr)) begin
        next_st.bresp = ofs_pkg::OFS_RESP_SLVERR;
      end else if (wa == ofs_pkg::OFS_ADDR_CODE) begin
        next_st.codes = mergeBytes(st.codes, next_st.wData, next_st.wStrb);
      end else if (wa == ofs_pkg::OFS_ADDR_CTRL) begin
        if (next_st.wStrb[0]) begin
          next_st.fastMode = ofs_pkg::ofs_fast_mode_e'(next_st.wData[0]);
        end
      end else if (wa == ofs_pkg::OFS_ADDR_VIRT) begin
        next_st.virt = mergeBytes(st.virt, next_st.wData, next_st.wStrb);
      end
    end
    // Stalling ready while a response waits keeps one write in flight
    next_st.awready = !next_st.awHeld && !next_st.bvalid;
    next_st.wready  = !next_st.wHeld && !next_st.bvalid;

    // Read channel
    if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    if (st.arready && arvalid) begin
      ra = 5'(araddr);
      next_st.rvalid = 1'b1;
      next_st.rdata  = 32'h0000_0000;
      next_st.rresp  = ofs_pkg::OFS_RESP_OKAY;
      if (!isMapped(araddr)) begin
        next_st.rresp = ofs_pkg::OFS_RESP_SLVERR;
      end else if (ra == ofs_pkg::OFS_ADDR_CODE) begin
        next_st.rdata = st.codes & 32'h3f3f_3f3f;
      end else if (ra == ofs_pkg::OFS_ADDR_CTRL) begin
        next_st.rdata = {31'h0000_0000, st.fastMode};
      end else if (ra == ofs_pkg::OFS_ADDR_VIRT) begin
        next_st.rdata = st.virt & 32'h000f_0f0f;
      end else begin
        next_st.rdata[3:0] = st.term;
        next_st.rdata[ofs_pkg::OFS_STAT_HOLD_POS] = hold.active;
      end
    end
    next_st.arready = !next_st.rvalid;

    // Terminals share one code list and may pick the same code
    for (int t = 0; t < 4; t++) begin
      vb = {st.virt[t + 2*ofs_pkg::OFS_VIRT_LINK_POS],
            st.virt[t + ofs_pkg::OFS_VIRT_LINK_POS],
            st.virt[t]};
      on = termOn(st.codes[t*8 +: 6], stat, vb);
      next_st.term[t] = on;
    end
    // Pulse scaling lives elsewhere; the pulse train is passed as is
    if (st.fastMode == ofs_pkg::OFS_FAST_PULSE) begin
      next_st.term[3] = fastPulseIn;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st          <= '0;
      st.codes    <= ofs_pkg::OFS_RST_CODE;
      st.virt     <= ofs_pkg::OFS_RST_VIRT;
      st.fastMode <= ofs_pkg::OFS_FAST_LEVEL;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign awready             = st.awready;
  assign wready              = st.wready;
  assign bvalid              = st.bvalid;
  assign bresp               = st.bresp;
  assign arready             = st.arready;
  assign rvalid              = st.rvalid;
  assign rdata               = st.rdata;
  assign rresp               = st.rresp;
  assign relayOne            = st.term[0];
  assign relayTwo            = st.term[1];
  assign openCollector       = st.term[2];
  assign fast_pulse_terminal = st.term[3];

endmodule : ofs_top
`default_nettype wire

// ---- testbench/ofs_term_model.sv ----
/*
  Far-side model: a pulse counter reading the fast terminal of the four.
  Assumes terminal levels synchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module ofs_term_model (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic [3:0] term,
  output logic      [7:0] fastRises
);
  logic last;
  // Counts pulses seen on the fast terminal
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      last      <= 1'b0;
      fastRises <= 8'h00;
    end else begin
      last <= term[3];
      if (term[3] && !last) fastRises <= fastRises + 8'h01;
    end
  end
endmodule : ofs_term_model
`default_nettype wire

// ---- testbench/ofs_top_sva.sv ----
/*
  Checker on the selector's ports.
  Assumes code writes come with full strobes, address and data together.
*/
`timescale 1ns/1ps
`default_nettype none
module ofs_top_sva #(
  parameter int ADDR_W = 5
) (
  input wire logic              clk_sys,
  input wire logic              rstn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic [31:0]       wdata,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic [1:0]        bresp,
  input wire logic              bvalid,
  input wire logic              bready,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [31:0]       rdata,
  input wire logic              rvalid,
  input wire logic              rready,
  input wire logic              freqOut,
  input wire logic              running,
  input wire logic              fault,
  input wire logic              relayOne,
  input wire logic              relayTwo,
  input wire logic              openCollector
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Shadow of the code word, snooped off the bus
  logic [31:0] code;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) code <= '0;
    else if (awvalid && awready && wvalid && wready && awaddr == ofs_pkg::OFS_ADDR_CODE)
      code <= wdata;
  end
  chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  chk_ar_busy: assert property (rvalid |-> !arready)
    else $error("read taken while busy");
  chk_b_after: assert property (awvalid && awready && wvalid && wready |=> bvalid)
    else $error("write response late");
  chk_r_after: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  chk_code_zero: assert property ($past(code[21:16]) == 6'h00 |-> !openCollector)
    else $error("idle terminal on");
  chk_undef_off: assert property ($past(code[5:0]) inside {[6'h12:6'h16], [6'h22:6'h3f]}
    |-> !relayOne) else $error("undefined code drives terminal");
  chk_fault_map: assert property ($past(code[5:0]) == 6'h05 |-> relayOne == $past(fault))
    else $error("fault not mirrored");
  chk_run_map: assert property ($past(code[13:8]) == 6'h01
    |-> relayTwo == $past(freqOut && running)) else $error("running not mirrored");
  cov_write: cover property (bvalid && bready);
  cov_read: cover property (rvalid && rready);
  cov_fault: cover property (code[5:0] == 6'h05 && relayOne);
endmodule : ofs_top_sva
bind ofs_top ofs_top_sva #(.ADDR_W(ADDR_W)) u_sva (.*);
`default_nettype wire

// ---- testbench/tb_top.sv ----
/*
  Self-checking bench for the selector.
  Assumes a 25 MHz clock and a shortened index hold.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int HOLD = 20;
  localparam logic [4:0] ACODE = ofs_pkg::OFS_ADDR_CODE;
  localparam logic [4:0] ACTRL = ofs_pkg::OFS_ADDR_CTRL;
  localparam logic [4:0] AVIRT = ofs_pkg::OFS_ADDR_VIRT;
  localparam logic [1:0] OK = ofs_pkg::OFS_RESP_OKAY;
  localparam logic [1:0] ERR = ofs_pkg::OFS_RESP_SLVERR;
  logic clk_sys, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic relayOne, relayTwo, openCollector, fast_pulse_terminal;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [30:0] s, m;
  logic [7:0] rises, r0;
  logic [5:0] cd;
  int fails, n_tests, hi;
  logic [31:0] vv[3] = '{32'h1, 32'h2_0000, 32'h408};
  logic [3:0] ve[3] = '{4'h1, 4'h2, 4'hc};
  ofs_top #(.HOLD_CYCLES(HOLD)) dut (.*,
    .freqOut(s[0]), .running(s[1]), .runFwd(s[2]), .runRev(s[3]), .jogging(s[4]),
    .fault(s[5]), .freq_level_flag_one(s[6]), .freq_level_flag_two(s[7]),
    .freqReached(s[8]), .outFreqZero(s[9]), .refFreqZero(s[10]), .upperLimit(s[11]),
    .lowerLimit(s[12]), .mainPowerOk(s[13]), .ctrlPowerOk(s[14]), .protectActive(s[15]),
    .readyToRun(s[16]), .preExcite(s[17]), .overloadAlarm(s[18]), .underloadAlarm(s[19]),
    .seqStageDone(s[20]), .seqCycleDone(s[21]), .busAboveUv(s[22]), .encIndex(s[23]),
    .superpose(s[24]), .safe_torque_off(s[25]), .positionDone(s[26]),
    .spindleZeroDone(s[27]), .spindleDivDone(s[28]), .torqueSpeedLimit(s[29]),
    .fastPulseIn(s[30]));
  ofs_term_model tm (.clk_sys(clk_sys), .rstn(rstn), .fastRises(rises),
    .term({fast_pulse_terminal, openCollector, relayTwo, relayOne}));
  always #20 clk_sys = ~clk_sys;
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (!ok) begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk
  task automatic bound(input int n);
    if (n >= 50) begin
      chk(1'b0, "bus timeout");
      final_report();
    end
  endtask : bound
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bound(n);
    chk(bresp === e, "write response");
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    bound(n);
    chk(rdata === e && rresp === er, "read data");
  endtask : rd
  // Waits two edges so the registered terminals catch up
  task automatic term(input logic [30:0] v, input logic [3:0] e);
    s <= v;
    repeat (2) @(posedge clk_sys);
    chk({fast_pulse_terminal, openCollector, relayTwo, relayOne} === e, "terminals");
  endtask : term
  task automatic do_reset;
    rstn <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask : do_reset
  function automatic logic [30:0] need(input int k);
    need = '0;
    if (k >= 1 && k <= 4) need = 31'h1 | (31'h1 << k);
    else if (k >= 5 && k <= 8) need = 31'h1 << k;
    else if (k == 9) need = 31'h600;
    else if (k == 10 || k == 11) need = 31'h1 << (k + 1);
    else if (k == 12) need = 31'h1_6000;
    else if (k >= 13 && k <= 17) need = 31'h1 << (k + 4);
    else if (k == 26) need = 31'h40_0000;
    else if (k == 28) need = 31'h100_0000;
    else if (k >= 29 && k <= 33) need = 31'h1 << (k - 4);
  endfunction : need
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    rstn = 1'b0;
    {awvalid, wvalid, arvalid} = '0;
    {bready, rready} = 2'b11;
    {awaddr, araddr, wdata, s} = '0;
    wstrb = 4'hf;
    fails = 0;
    n_tests = 0;
    do_reset();
    term(31'h0, 4'h0);
    rd(ACODE, ofs_pkg::OFS_RST_CODE, OK);
    rd(AVIRT, ofs_pkg::OFS_RST_VIRT, OK);
    wr(ACODE, 32'hffff_ffff, OK);
    rd(ACODE, 32'h3f3f_3f3f, OK);
    wr(5'h14, 32'h1, ERR);
    rd(5'h10, 32'h0, ERR);
    $display("registers done");
    for (int k = 0; k < 37; k++) begin
      cd = (k == 36) ? 6'h3f : 6'(k);
      if (cd inside {[6'h17:6'h19], 6'h1b}) continue;
      wr(ACODE, {4{2'b00, cd}}, OK);
      m = need(cd);
      term(31'h0, 4'h0);
      if (m == 0) term(31'h3f7f_ffff, 4'h0);
      else if (cd < 12) term(m, 4'hf);
      else term(m, 4'hf);
      if ($countones(m) > 1) term(m & (m - 31'h1), 4'h0);
      if (cd == 12) term(m | 31'h8000, 4'h0);
    end
    $display("code sweep done");
    wr(ACODE, {8'h1d, 8'h00, 8'h1a, 8'h05}, OK);
    term(31'h20, 4'h1);
    term(31'h40_0000, 4'h2);
    term(31'h200_0000, 4'h8);
    wr(ACODE, {8'h17, 8'h18, 8'h19, 8'h17}, OK);
    for (int i = 0; i < 3; i++) begin
      wr(AVIRT, vv[i], OK);
      term(31'h0, ve[i]);
    end
    $display("virtual outputs done");
    wr(ACODE, 32'h1b, OK);
    term(31'h0, 4'h0);
    s <= 31'h80_0000;
    @(posedge clk_sys);
    s <= 31'h0;
    hi = 0;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk_sys);
      if (relayOne === 1'b1) hi++;
    end
    chk(hi == HOLD, "index hold");
    wr(ACODE, 32'h0, OK);
    for (int p = 0; p < 2; p++) begin
      wr(ACTRL, (p == 0) ? 32'h1 : 32'h0, OK);
      r0 = rises;
      for (int i = 0; i < 5; i++) begin
        s <= 31'h4000_0000;
        @(posedge clk_sys);
        s <= 31'h0;
        @(posedge clk_sys);
      end
      repeat (3) @(posedge clk_sys);
      chk(8'(rises - r0) === ((p == 0) ? 8'h05 : 8'h00), "fast mode");
    end
    $display("fast terminal done");
    wr(ACODE, 32'h0505_0505, OK);
    term(31'h20, 4'hf);
    rd(ofs_pkg::OFS_ADDR_STAT, 32'hf, OK);
    rstn <= 1'b0;
    @(posedge clk_sys);
    chk({fast_pulse_terminal, openCollector, relayTwo, relayOne} === 4'h0, "reset");
    do_reset();
    rd(ACODE, 32'h0, OK);
    term(31'h20, 4'h0);
    $display("mid-run reset done");
    final_report();
  end
endmodule : tb_top
`default_nettype wire
